// [hw/restart_pkg.sv]
package restart_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned TICK_HZ = 1000;
	localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
	localparam int unsigned PRESS_MIN_MS = 150;
	localparam int unsigned PRESS_MAX_MS = 4000;
	localparam int unsigned SEQ_GAP_MS = 4000;
	localparam int unsigned OVR_LONG_S = 120;
	localparam int unsigned OVR_SHORT_S = 5;
	localparam int unsigned OVR_LONG_MS = OVR_LONG_S * 1000;
	localparam int unsigned OVR_SHORT_MS = OVR_SHORT_S * 1000;
	localparam int unsigned MS_W = 17;
	localparam int unsigned DIV_W = 17;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_LOCKED,
		ST_RUN,
		ST_MUTE_FAULT,
		ST_MUTE_GAP,
		ST_OVERRIDE,
		ST_OVR_VALID
	} state_t;

	typedef struct packed {
		logic beam_clear;
		logic mute_fault;
		logic mute_valid;
		logic seq_two_sensor;
	} sense_t;

	typedef struct packed {
		logic red;
		logic yellow;
		logic green;
		logic mute_steady;
		logic mute_flash;
	} lamps_t;
endpackage

// [hw/restart_interlock_button_logic.sv]
`timescale 1ns/10ps
`default_nettype none
module restart_interlock_button_logic
	import restart_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_DIV
)
(
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire logic BUTTON,
	input wire logic CTRL_RESTART,
	input wire sense_t SENSE,
	output logic SAFETY_SWITCHING_OUTPUTS,
	output lamps_t LAMPS
);
	// ------------------------------------------------------------
	// Millisecond tick
	// ------------------------------------------------------------
	logic [DIV_W-1:0] div_r, div_nxt;
	logic tick_r, tick_nxt;

	always_comb begin
		tick_nxt = 1'b0;
		div_nxt = div_r + 1'b1;
		if (div_r == DIV_W'(TICK_CYCLES - 1)) begin
			div_nxt = '0;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			div_r <= '0;
			tick_r <= 1'b0;
		end else begin
			div_r <= div_nxt;
			tick_r <= tick_nxt;
		end
	end

	// ------------------------------------------------------------
	// Button edges
	// ------------------------------------------------------------
	logic btn_r, btn_nxt;
	logic press, rel_edge;

	always_comb begin
		btn_nxt = BUTTON | CTRL_RESTART;
	end

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			btn_r <= 1'b0;
		end else begin
			btn_r <= btn_nxt;
		end
	end

	assign press = btn_nxt & ~btn_r;
	assign rel_edge = ~btn_nxt & btn_r;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	state_t state_r, state_nxt;
	logic [MS_W-1:0] ms_r, ms_nxt;
	logic ovr_short_r, ovr_short_nxt;
	logic out_r, out_nxt;
	lamps_t lamps_r, lamps_nxt;
	logic [8:0] blink_r, blink_nxt;
	logic held_ok;
	logic ovr_expired;
	logic gap_expired;
	logic [MS_W-1:0] ovr_limit;

	// Count saturates so a stuck button cannot wrap into the window
	always_comb begin
		held_ok = 1'b0;
		if ((ms_r >= MS_W'(PRESS_MIN_MS)) && (ms_r <= MS_W'(PRESS_MAX_MS))) begin
			held_ok = 1'b1;
		end
		// Limit chosen at the second press; later mode changes do not stretch it
		ovr_limit = MS_W'(OVR_LONG_MS);
		if (ovr_short_r) begin
			ovr_limit = MS_W'(OVR_SHORT_MS);
		end
		ovr_expired = (ms_r >= ovr_limit);
		gap_expired = (ms_r > MS_W'(SEQ_GAP_MS));
	end

	always_comb begin
		state_nxt = state_r;
		ovr_short_nxt = ovr_short_r;
		ms_nxt = ms_r;
		if (tick_r && ms_r != '1) begin
			ms_nxt = ms_r + 1'b1;
		end
		if (press || rel_edge) begin
			ms_nxt = '0;
		end
		case (state_r)
			ST_LOCKED: begin
				if (rel_edge && held_ok) begin
					state_nxt = ST_RUN;
				end
				// Short or overlong press just restarts timing
			end
			ST_RUN: begin
				if (SENSE.mute_fault) begin
					state_nxt = ST_MUTE_FAULT;
				end else if (!SENSE.beam_clear && !SENSE.mute_valid) begin
					state_nxt = ST_LOCKED;
				end
			end
			ST_MUTE_FAULT: begin
				if (rel_edge) begin
					state_nxt = held_ok ? ST_MUTE_GAP : ST_MUTE_FAULT;
				end
			end
			ST_MUTE_GAP: begin
				if (press) begin
					state_nxt = ST_OVERRIDE;
					ovr_short_nxt = SENSE.seq_two_sensor;
				end else if (gap_expired) begin
					state_nxt = ST_MUTE_FAULT;
				end
			end
			ST_OVERRIDE: begin
				if (SENSE.mute_valid) begin
					state_nxt = ST_OVR_VALID;
				end else if (rel_edge || ovr_expired) begin
					state_nxt = ST_LOCKED;
				end
			end
			ST_OVR_VALID: begin
				if (!btn_nxt) begin
					state_nxt = SENSE.mute_valid ? ST_RUN : ST_LOCKED;
				end
			end
			default: begin
				state_nxt = ST_LOCKED;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_r <= ST_LOCKED;
			ms_r <= '0;
			ovr_short_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ms_r <= ms_nxt;
			ovr_short_r <= ovr_short_nxt;
		end
	end

	// ------------------------------------------------------------
	// Indicators and output enable
	// ------------------------------------------------------------
	// Decoded from next state so lamps and outputs switch on one edge
	always_comb begin
		blink_nxt = blink_r;
		if (tick_r) begin
			blink_nxt = blink_r + 1'b1;
		end
		out_nxt = 1'b0;
		if ((state_nxt == ST_RUN) || (state_nxt == ST_OVERRIDE)
			|| (state_nxt == ST_OVR_VALID)) begin
			out_nxt = 1'b1;
		end
		lamps_nxt = '0;
		lamps_nxt.green = out_nxt;
		if (state_nxt == ST_LOCKED) begin
			lamps_nxt.red = 1'b1;
			lamps_nxt.yellow = SENSE.beam_clear;
		end else if (!out_nxt) begin
			// Muting fault states keep the machine stopped
			lamps_nxt.red = 1'b1;
		end
		if ((state_nxt == ST_MUTE_FAULT) || (state_nxt == ST_MUTE_GAP)) begin
			lamps_nxt.mute_flash = blink_r[8];
		end
		lamps_nxt.mute_steady = out_nxt && SENSE.mute_valid;
	end

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			out_r <= 1'b0;
			lamps_r <= '0;
			blink_r <= '0;
		end else begin
			out_r <= out_nxt;
			lamps_r <= lamps_nxt;
			blink_r <= blink_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Straight from flops so no decode glitch reaches the switching stage

	assign SAFETY_SWITCHING_OUTPUTS = out_r;
	assign LAMPS = lamps_r;
endmodule
`default_nettype wire

// [dv/restart_props.sv]
`timescale 1ns/10ps
`default_nettype none
module restart_props
	import restart_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire logic BUTTON,
	input wire logic CTRL_RESTART,
	input wire sense_t SENSE,
	input wire logic SAFETY_SWITCHING_OUTPUTS,
	input wire lamps_t LAMPS
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);
	wire logic press = BUTTON | CTRL_RESTART;
	locked_off_a: assert property (LAMPS.red |-> !SAFETY_SWITCHING_OUTPUTS)
		else $error("enabled while locked");
	yellow_field_a: assert property (LAMPS.red && LAMPS.yellow |->
		$past(SENSE.beam_clear)) else $error("yellow wrong");
	unlock_on_release_a: assert property ($rose(SAFETY_SWITCHING_OUTPUTS) &&
		!$past(press) |-> $past(press, 2)) else $error("bad unlock");
	green_match_a: assert property (LAMPS.green == SAFETY_SWITCHING_OUTPUTS)
		else $error("green differs from outputs");
	flash_stopped_a: assert property (LAMPS.mute_flash |-> !SAFETY_SWITCHING_OUTPUTS)
		else $error("enabled while muting fault flashes");
	steady_on_a: assert property (LAMPS.mute_steady |-> SAFETY_SWITCHING_OUTPUTS)
		else $error("steady muting lamp with outputs off");
	run_lamps_a: assert property (SAFETY_SWITCHING_OUTPUTS |-> !LAMPS.red)
		else $error("red with outputs on");
endmodule
bind restart_interlock_button_logic restart_props u_props(.CORE_CLK, .RST_B, .BUTTON,
	.CTRL_RESTART, .SENSE, .SAFETY_SWITCHING_OUTPUTS, .LAMPS);
`default_nettype wire

// [dv/restart_operator.sv]
`timescale 1ns/10ps
`default_nettype none
module restart_operator (
	input wire logic CORE_CLK,
	output logic BUTTON
);
	initial BUTTON = 1'h0;
	// Hold counted in clock cycles; a full-length hold is too long to simulate
	task automatic press(input int n);
		@(posedge CORE_CLK);
		#1 BUTTON = 1'h1;
		repeat (n) @(posedge CORE_CLK);
		#1 BUTTON = 1'h0;
	endtask
endmodule
`default_nettype wire

// [dv/test_restart_interlock_button_logic.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin num_errors++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module test_restart_interlock_button_logic
	import restart_pkg::*;
;
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic ctrl = 1'h0;
	logic button;
	logic sso;
	sense_t sense = '0;
	lamps_t lamps;
	int num_errors = 0;
	int num_checks = 0;
	always #4 clk = ~clk;
	restart_operator u_op(.CORE_CLK(clk), .BUTTON(button));
	// Fast tick so windows of thousands of ms fit the run
	restart_interlock_button_logic #(.TICK_CYCLES(10)) u_dut(.CORE_CLK(clk), .RST_B(rst_b),
		.BUTTON(button),
		.CTRL_RESTART(ctrl), .SENSE(sense), .SAFETY_SWITCHING_OUTPUTS(sso), .LAMPS(lamps));
	task final_report;
		if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task wait_n(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task check_locked(input logic clr);
		`CHK("outputs", 1'h0, sso)
		`CHK("red", 1'h1, lamps.red)
		`CHK("yellow", clr, lamps.yellow)
	endtask
	task long_press;
		u_op.press(41000);
		wait_n(3);
		check_locked(1'h1);
	endtask
	task unlock_run;
		u_op.press(2000);
		wait_n(2);
		`CHK("outputs", 1'h1, sso)
		`CHK("green", 1'h1, lamps.green)
		`CHK("red", 1'h0, lamps.red)
		sense.beam_clear = 1'h0;
		wait_n(3);
		check_locked(1'h0);
		sense.beam_clear = 1'h1;
		wait_n(2);
		u_op.press(2000);
		wait_n(2);
		`CHK("outputs", 1'h1, sso)
	endtask
	// Second press comes from the controller input
	task mute_restart(input logic valid);
		sense.mute_fault = 1'h1;
		wait_n(2);
		`CHK("fault outputs", 1'h0, sso)
		`CHK("fault red", 1'h1, lamps.red)
		sense.mute_fault = 1'h0;
		u_op.press(2000);
		wait_n(3);
		ctrl = 1'h1;
		wait_n(3);
		`CHK("override outputs", 1'h1, sso)
		sense.mute_valid = valid;
		wait_n(3);
		ctrl = 1'h0;
		wait_n(3);
		`CHK("end outputs", valid, sso)
		`CHK("mute lamp", valid, lamps.mute_steady)
		sense.mute_valid = 1'h0;
		wait_n(2);
	endtask
	task reset_state;
		wait_n(8);
		rst_b = 1'h1;
		sense.beam_clear = 1'h1;
		wait_n(2);
		check_locked(1'h1);
	endtask
	task field_blocked;
		sense.beam_clear = 1'h0;
		wait_n(2);
		check_locked(1'h0);
		sense.beam_clear = 1'h1;
		wait_n(2);
		check_locked(1'h1);
	endtask
	// Holds far below the minimum must leave the interlock shut
	task short_press;
		u_op.press(100);
		wait_n(3);
		check_locked(1'h1);
	endtask
	task ctrl_short;
		ctrl = 1'h1;
		wait_n(100);
		ctrl = 1'h0;
		wait_n(3);
		check_locked(1'h1);
	endtask
	initial begin
		reset_state();
		field_blocked();
		short_press();
		ctrl_short();
		long_press();
		unlock_run();
		mute_restart(1'h1);
		mute_restart(1'h0);
		final_report();
	end
endmodule
`default_nettype wire
